//--- rtl/isp_pkg.sv
// Constants of the serial programming port: opcodes, memory geometry, reset values, timing.
// Assumes a core clock of 250 MHz; all counts derive from that rate.
package isp_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam real CLK_MHZ = 250.0;
    localparam real WRITE_BUSY_MIN_MS = 3.7;
    localparam real WRITE_BUSY_MAX_MS = 4.5;
    localparam real ERASE_BUSY_MIN_MS = 7.5;
    localparam real ERASE_BUSY_MAX_MS = 9.0;
    localparam int WRITE_BUSY_CYC = int'($ceil(WRITE_BUSY_MIN_MS * 1000.0 * CLK_MHZ));
    localparam int ERASE_BUSY_CYC = int'($ceil(ERASE_BUSY_MIN_MS * 1000.0 * CLK_MHZ));
    localparam int BUSY_W = 24;

    // ****************************************
    // Instruction bytes
    // ****************************************
    localparam logic [7:0] OP_ACCESS = 8'hAC;
    localparam logic [7:0] OP_ENABLE_B2 = 8'h53;
    localparam logic [2:0] OP_ERASE_B2 = 3'h4;
    localparam logic [2:0] OP_LOCK_B2 = 3'h7;
    localparam logic [7:0] OP_FUSE_LO_B2 = 8'hA0;
    localparam logic [7:0] OP_FUSE_HI_B2 = 8'hA8;
    localparam logic [7:0] OP_FUSE_EXT_B2 = 8'hA4;
    localparam logic [7:0] OP_RD_FLASH = 8'h20;
    localparam logic [7:0] OP_LD_FLASH = 8'h40;
    localparam logic [7:0] OP_WR_FPAGE = 8'h4C;
    localparam logic [7:0] OP_RD_EE = 8'hA0;
    localparam logic [7:0] OP_WR_EE = 8'hC0;
    localparam logic [7:0] OP_LD_EE = 8'hC1;
    localparam logic [7:0] OP_WR_EPAGE = 8'hC2;
    localparam logic [7:0] OP_RD_LOCK = 8'h58;
    localparam logic [7:0] OP_RD_FUSE = 8'h50;
    localparam logic [7:0] OP_RD_SIG = 8'h30;
    localparam logic [7:0] OP_RD_CAL = 8'h38;
    localparam logic [7:0] OP_POLL = 8'hF0;
    localparam logic [7:0] OP_HI_SEL_B2 = 8'h08;
    localparam int OP_HBYTE_BIT = 3;

    // ****************************************
    // Memory geometry and reset values
    // ****************************************
    localparam int FLASH_AW = 10;
    localparam int FWORD_W = 4;
    localparam int FPAGE_W = 6;
    localparam int EE_AW = 7;
    localparam int EBYTE_W = 2;
    localparam int EPAGE_W = 5;
    localparam int FRAME_BITS = 32;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [7:0] FUSE_LO_RST = 8'hFF;
    localparam logic [7:0] FUSE_HI_RST = 8'hFF;
    localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [1:0] LOCK_FIXED = 2'h3;

    typedef enum logic [1:0] {ST_OFF, ST_READY, ST_ERASE} isp_state_t;

endpackage : isp_pkg

//--- rtl/isp_link.sv
// Serial shifter on the programmer's clock: collects 32-bit frames, drives the answer bit.
// Assumes rd_data is stable from a few core cycles after head_tgl until the next frame.
`timescale 1ns/100ps
module isp_link
(
    input wire logic sck,
    input wire logic link_rst,
    input wire logic mosi,
    input wire logic [7:0] rd_data,
    output logic miso,
    output logic [31:0] frame,
    output logic frame_tgl,
    output logic [23:0] head,
    output logic head_tgl
);

    logic [30:0] rx;
    logic [4:0] cnt;
    logic [7:0] tx;

    // ****************************************
    // Receive on the rising edge
    // ****************************************
    always_ff @(posedge sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            rx <= '0;
            cnt <= 5'h00;
        end
        else
        begin
            rx <= {rx[29:0], mosi};
            cnt <= cnt + 5'h01;
        end
    end

    always_ff @(posedge sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            frame <= '0;
            frame_tgl <= 1'b0;
            head <= '0;
            head_tgl <= 1'b0;
        end
        else if (cnt == 5'h1F)
        begin
            frame <= {rx, mosi};
            frame_tgl <= ~frame_tgl;
        end
        else if (cnt == 5'h17)
        begin
            head <= {rx[22:0], mosi};
            head_tgl <= ~head_tgl;
        end
    end

    // ****************************************
    // Transmit on the falling edge
    // ****************************************
    always_ff @(negedge sck or posedge link_rst)
    begin
        if (link_rst)
            tx <= 8'h00;
        else if (cnt == 5'h10)
            tx <= rx[7:0];
        else if (cnt == 5'h18)
            tx <= rd_data;
        else
            tx <= {tx[6:0], 1'b0};
    end

    assign miso = tx[7];

endmodule : isp_link

//--- rtl/isp_busy_timer.sv
// Self-timed operation counter: busy stays high for exactly span enabled cycles after start.
// Assumes start is only raised while busy is low.
`timescale 1ns/100ps
module isp_busy_timer
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic start,
    input wire logic [isp_pkg::BUSY_W-1:0] span,
    output logic busy
);

    logic [isp_pkg::BUSY_W-1:0] remain;
    logic [isp_pkg::BUSY_W-1:0] span_q;
    logic [isp_pkg::BUSY_W-1:0] elapsed;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            remain <= '0;
            busy <= 1'b0;
        end
        else if (ce)
        begin
            if (start && !busy)
            begin
                remain <= span;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                remain <= remain - 24'h00_0001;
                busy <= (remain != 24'h00_0001);
            end
        end
    end

    // Helper for the length check
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            span_q <= '0;
            elapsed <= '0;
        end
        else if (ce && start && !busy)
        begin
            span_q <= span;
            elapsed <= '0;
        end
        else if (ce && busy)
            elapsed <= elapsed + 24'h00_0001;
    end

    busy_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(busy) |-> elapsed == span_q)
        else $error("busy length differs from requested span");

endmodule : isp_busy_timer

//--- rtl/isp_port.sv
// Serial in-system programming port: frame decode, memories, fuses and busy timing.
// Assumes sck runs only while the reset pin is low and respects the slow-phase limits.
//
// Contract
// - Serial programming works only while the reset pin is held low.
// - An EEPROM byte write erases and writes the location in one timed step.
// - Chip erase sets every flash and EEPROM location to 0xFF.
// - Input sampled on rising sck; output shifted on falling sck.
// - Second enable byte 0x53 echoes while the third byte shifts in.
// - Flash loads words by 4 low bits, commits page by 6 high bits.
// - EEPROM page buffer uses 2 low bits; commit uses 5 high bits.
// - EEPROM page write changes only the loaded byte locations.
// - A read returns the stored content during the same frame.
// - Releasing reset high ends programming mode, normal operation follows.
// - Self-timed writes keep the device busy 3.7 to 4.5 ms.
// - Chip erase keeps the device busy 7.5 to 9 ms.
// - Programming enable is AC 53 followed by two don't-care bytes.
// - Poll instruction F0 returns busy in the last output bit.
`timescale 1ns/100ps
module isp_port
#(
    parameter int WRITE_BUSY_CYC = isp_pkg::WRITE_BUSY_CYC,
    parameter int ERASE_BUSY_CYC = isp_pkg::ERASE_BUSY_CYC,
    parameter logic [7:0] SIG0 = 8'h5A, // Arbitrary value
    parameter logic [7:0] SIG1 = 8'hA5, // Arbitrary value
    parameter logic [7:0] SIG2 = 8'h3C, // Arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80 // Arbitrary value
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic sck,
    input wire logic reset_n_pin,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic prog_mode,
    output logic busy
);

    isp_pkg::isp_state_t state;
    logic [31:0] frame;
    logic [23:0] head;
    logic frame_tgl, head_tgl, link_rst;
    logic rp_s1, rp_s2, ft_s1, ft_s2, ft_s3, ht_s1, ht_s2, ht_s3;
    logic frame_ev, head_ev, accept, loadable, start;
    logic do_erase, do_fpage, do_ebyte, do_epage, do_lock, do_fuse, load_f, load_e;
    logic [7:0] b1, b2, b3, b4, h1, h2, h3, rd_data;
    logic [7:0] fuse_lo, fuse_hi, fuse_ext, lock;
    logic [3:0] eload;
    logic [isp_pkg::FLASH_AW-1:0] sweep;
    logic [7:0] flash_lo [0:(1<<isp_pkg::FLASH_AW)-1];
    logic [7:0] flash_hi [0:(1<<isp_pkg::FLASH_AW)-1];
    logic [7:0] eeprom [0:(1<<isp_pkg::EE_AW)-1];
    logic [7:0] fbuf_lo [0:(1<<isp_pkg::FWORD_W)-1];
    logic [7:0] fbuf_hi [0:(1<<isp_pkg::FWORD_W)-1];
    logic [7:0] ebuf [0:(1<<isp_pkg::EBYTE_W)-1];

    // ****************************************
    // Link side
    // ****************************************
    assign link_rst = sys_rst | reset_n_pin;

    isp_link u_link
    (
        .sck(sck),
        .link_rst(link_rst),
        .mosi(mosi),
        .rd_data(rd_data),
        .miso(miso),
        .frame(frame),
        .frame_tgl(frame_tgl),
        .head(head),
        .head_tgl(head_tgl)
    );

    // ****************************************
    // Crossing into the core clock
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {rp_s1, rp_s2} <= 2'h3;
            {ft_s1, ft_s2, ft_s3} <= 3'h0;
            {ht_s1, ht_s2, ht_s3} <= 3'h0;
            prog_mode <= 1'b0;
        end
        else if (ce)
        begin
            {rp_s1, rp_s2} <= {reset_n_pin, rp_s1};
            {ft_s1, ft_s2, ft_s3} <= {frame_tgl, ft_s1, ft_s2};
            {ht_s1, ht_s2, ht_s3} <= {head_tgl, ht_s1, ht_s2};
            prog_mode <= ~rp_s2;
        end
    end

    assign miso_oe = prog_mode;
    assign frame_ev = ce && prog_mode && (ft_s2 ^ ft_s3);
    assign head_ev = ce && prog_mode && (ht_s2 ^ ht_s3);
    assign {b1, b2, b3, b4} = frame;
    assign {h1, h2, h3} = head;

    // ****************************************
    // Frame decode
    // ****************************************
    assign loadable = frame_ev && state != isp_pkg::ST_OFF;
    assign accept = frame_ev && state == isp_pkg::ST_READY && !busy;
    assign do_erase = accept && b1 == isp_pkg::OP_ACCESS && b2[7:5] == isp_pkg::OP_ERASE_B2;
    assign do_lock = accept && b1 == isp_pkg::OP_ACCESS && b2[7:5] == isp_pkg::OP_LOCK_B2;
    assign do_fuse = accept && b1 == isp_pkg::OP_ACCESS
        && (b2 == isp_pkg::OP_FUSE_LO_B2 || b2 == isp_pkg::OP_FUSE_HI_B2
        || b2 == isp_pkg::OP_FUSE_EXT_B2);
    assign do_fpage = accept && b1 == isp_pkg::OP_WR_FPAGE;
    assign do_ebyte = accept && b1 == isp_pkg::OP_WR_EE;
    assign do_epage = accept && b1 == isp_pkg::OP_WR_EPAGE;
    assign load_f = loadable && {b1[7:4], b1[2:0]} == isp_pkg::OP_LD_FLASH[7:1];
    assign load_e = loadable && b1 == isp_pkg::OP_LD_EE;
    assign start = do_erase | do_lock | do_fuse | do_fpage | do_ebyte | do_epage;

    isp_busy_timer u_timer
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .start(start),
        .span(do_erase ? 24'(ERASE_BUSY_CYC) : 24'(WRITE_BUSY_CYC)),
        .busy(busy)
    );

    // ****************************************
    // Mode state
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= isp_pkg::ST_OFF;
        else if (ce)
        begin
            if (!prog_mode)
                state <= isp_pkg::ST_OFF;
            else
            begin
                case (state)
                    isp_pkg::ST_OFF:
                        if (frame_ev && b1 == isp_pkg::OP_ACCESS
                            && b2 == isp_pkg::OP_ENABLE_B2)
                            state <= isp_pkg::ST_READY;
                    isp_pkg::ST_READY:
                        if (do_erase)
                            state <= isp_pkg::ST_ERASE;
                    isp_pkg::ST_ERASE:
                        if (&sweep)
                            state <= isp_pkg::ST_READY;
                    default:
                        state <= isp_pkg::ST_OFF;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            sweep <= '0;
        else if (ce)
            sweep <= (state == isp_pkg::ST_ERASE) ? sweep + 10'h001 : 10'h000;
    end

    // ****************************************
    // Memories and page buffers
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (state == isp_pkg::ST_ERASE)
            begin
                flash_lo[sweep] <= isp_pkg::ERASED;
                flash_hi[sweep] <= isp_pkg::ERASED;
                eeprom[sweep[isp_pkg::EE_AW-1:0]] <= isp_pkg::ERASED;
            end
            if (do_fpage)
                for (int i = 0; i < (1 << isp_pkg::FWORD_W); i++)
                begin
                    flash_lo[{b2[1:0], b3[7:4], 4'(i)}] <= fbuf_lo[i];
                    flash_hi[{b2[1:0], b3[7:4], 4'(i)}] <= fbuf_hi[i];
                end
            if (do_ebyte)
                eeprom[b3[6:0]] <= b4;
            if (do_epage)
                for (int i = 0; i < (1 << isp_pkg::EBYTE_W); i++)
                    if (eload[i])
                        eeprom[{b3[6:2], 2'(i)}] <= ebuf[i];
        end
    end

    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (!prog_mode || do_fpage)
                for (int i = 0; i < (1 << isp_pkg::FWORD_W); i++)
                begin
                    fbuf_lo[i] <= isp_pkg::ERASED;
                    fbuf_hi[i] <= isp_pkg::ERASED;
                end
            else if (load_f && b1[isp_pkg::OP_HBYTE_BIT])
                fbuf_hi[b3[3:0]] <= b4;
            else if (load_f)
                fbuf_lo[b3[3:0]] <= b4;
            if (load_e)
                ebuf[b3[1:0]] <= b4;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            eload <= 4'h0;
        else if (ce)
        begin
            if (!prog_mode || do_epage)
                eload <= 4'h0;
            else if (load_e)
                eload[b3[1:0]] <= 1'b1;
        end
    end

    // ****************************************
    // Fuses and lock bits
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fuse_lo <= isp_pkg::FUSE_LO_RST;
            fuse_hi <= isp_pkg::FUSE_HI_RST;
            fuse_ext <= isp_pkg::FUSE_EXT_RST;
            lock <= isp_pkg::LOCK_RST;
        end
        else if (ce)
        begin
            if (do_erase)
                lock <= isp_pkg::LOCK_RST;
            else if (do_lock)
                lock <= {isp_pkg::LOCK_FIXED, b4[5:0]};
            if (do_fuse && b2 == isp_pkg::OP_FUSE_LO_B2)
                fuse_lo <= b4;
            if (do_fuse && b2 == isp_pkg::OP_FUSE_HI_B2)
                fuse_hi <= b4;
            if (do_fuse && b2 == isp_pkg::OP_FUSE_EXT_B2)
                fuse_ext <= {7'h7F, b4[0]};
        end
    end

    // ****************************************
    // Read answer, handed to the link before byte four
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_data <= 8'h00;
        else if (head_ev)
        begin
            if (h1 == isp_pkg::OP_POLL)
                rd_data <= {7'h00, busy};
            else if ({h1[7:4], h1[2:0]} == isp_pkg::OP_RD_FLASH[7:1])
                rd_data <= h1[isp_pkg::OP_HBYTE_BIT] ? flash_hi[{h2[1:0], h3}]
                    : flash_lo[{h2[1:0], h3}];
            else if (h1 == isp_pkg::OP_RD_EE)
                rd_data <= eeprom[h3[6:0]];
            else if (h1 == isp_pkg::OP_RD_LOCK)
                rd_data <= (h2 == isp_pkg::OP_HI_SEL_B2) ? fuse_hi : lock;
            else if (h1 == isp_pkg::OP_RD_FUSE)
                rd_data <= (h2 == isp_pkg::OP_HI_SEL_B2) ? fuse_ext : fuse_lo;
            else if (h1 == isp_pkg::OP_RD_SIG)
                rd_data <= (h3[1:0] == 2'h0) ? SIG0 : (h3[1:0] == 2'h1) ? SIG1 : SIG2;
            else if (h1 == isp_pkg::OP_RD_CAL)
                rd_data <= CAL_BYTE;
            else
                rd_data <= 8'h00;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence erase_cmd_s;
        ce && do_erase;
    endsequence

    sequence erase_run_s;
        (state == isp_pkg::ST_ERASE && busy) [*8];
    endsequence

    prog_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && !prog_mode |=> state == isp_pkg::ST_OFF)
        else $error("programming state held without reset pin low");
    enable_seq_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && state == isp_pkg::ST_OFF && frame_ev && b1 == isp_pkg::OP_ACCESS
        && b2 == isp_pkg::OP_ENABLE_B2 ##1 ce && prog_mode |-> state == isp_pkg::ST_READY)
        else $error("programming enable not taken");
    erase_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        erase_cmd_s |=> erase_run_s)
        else $error("chip erase did not start busy sweep");
    erase_fill_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && state == isp_pkg::ST_ERASE |=> flash_lo[$past(sweep)] == isp_pkg::ERASED
        && eeprom[$past(sweep[isp_pkg::EE_AW-1:0])] == isp_pkg::ERASED)
        else $error("erased location is not 0xFF");
    ee_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && do_ebyte |=> eeprom[$past(b3[6:0])] == $past(b4) && busy)
        else $error("EEPROM byte write lost or not timed");
    ee_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce && do_epage && !eload[0] |=> eeprom[{$past(b3[6:2]), 2'h0}]
        == $past(eeprom[{b3[6:2], 2'h0}]))
        else $error("unloaded EEPROM page byte changed");
    poll_a: assert property (@(posedge clk) disable iff (sys_rst)
        head_ev && h1 == isp_pkg::OP_POLL |=> rd_data == {7'h00, $past(busy)})
        else $error("poll answer does not show busy");
    ee_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        head_ev && h1 == isp_pkg::OP_RD_EE |=> rd_data == $past(eeprom[h3[6:0]]))
        else $error("EEPROM read returned wrong byte");

endmodule : isp_port

//--- verif/isp_prog_model.sv
// Programmer model: drives the reset pin and the serial link, gathers the answer bits.
// Assumes the port drives miso only while miso_oe is high.
`timescale 1ns/100ps
module isp_prog_model
#(
    parameter int HALF_NS = 32,
    parameter int WAKE_NS = 200,
    // Keeps link edges off the core clock edges
    parameter real SKEW_NS = 1.3
)
(
    output logic sck,
    output logic mosi,
    output logic reset_n_pin,
    input wire logic miso,
    input wire logic miso_oe
);
    // ****************************************
    // Link driver
    // ****************************************
    initial
    begin
        sck = 1'b0;
        mosi = 1'b0;
        reset_n_pin = 1'b1;
    end

    task automatic set_pin(input logic v);
        #(SKEW_NS);
        reset_n_pin = v;
        #(WAKE_NS);
    endtask : set_pin

    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        #(SKEW_NS);
        for (int i = 31; i >= 0; i--)
        begin
            mosi = tx[i];
            #(HALF_NS) sck = 1'b1;
            rx[i] = miso_oe ? miso : 1'bx;
            #(HALF_NS) sck = 1'b0;
        end
        // Released line shows the inverse of the last bit
        mosi = ~mosi;
    endtask : xfer
endmodule : isp_prog_model

//--- verif/serial_isp_programming_port_tb.sv
// Bench of the serial programming port: scenarios run through the programmer model.
// Assumes shortened busy counts; the link clock runs only within frames.
`timescale 1ns/100ps
`define isp_chk(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module serial_isp_programming_port_tb;
    localparam int WR_CYC = 40;
    localparam int ER_CYC = 2000;
    logic clk, sys_rst, ce, sck, mosi, reset_n_pin, miso, miso_oe, prog_mode, busy;
    logic [31:0] rx;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    isp_port #(.WRITE_BUSY_CYC(WR_CYC), .ERASE_BUSY_CYC(ER_CYC)) i_isp_port (.clk(clk),
        .sys_rst(sys_rst), .ce(ce), .sck(sck), .reset_n_pin(reset_n_pin), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .prog_mode(prog_mode), .busy(busy));
    isp_prog_model i_isp_prog_model (.sck(sck), .mosi(mosi), .reset_n_pin(reset_n_pin),
        .miso(miso), .miso_oe(miso_oe));

    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic send(input logic [31:0] tx);
        i_isp_prog_model.xfer(tx, rx);
        repeat (8) @(negedge clk);
    endtask : send

    task automatic wait_idle(output int cnt);
        cnt = 0;
        for (int k = 0; k < 700 && busy !== 1'b1; k++) @(negedge clk);
        while (busy === 1'b1 && cnt < 3000)
        begin
            @(negedge clk);
            cnt++;
        end
    endtask : wait_idle

    // Counts busy cycles of a timed frame, optionally sending a second frame meanwhile
    task automatic timed(input logic [31:0] a, input logic [31:0] b, output int cnt);
        fork
            begin
                i_isp_prog_model.xfer(a, rx);
                if (b !== 32'h0000_0000) i_isp_prog_model.xfer(b, rx);
            end
            wait_idle(cnt);
        join
        repeat (8) @(posedge clk);
    endtask : timed

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_enable;
        `isp_chk(prog_mode, 1'b0);
        i_isp_prog_model.set_pin(1'b0);
        `isp_chk(prog_mode, 1'b1);
        send(32'hAC53_0000);
        `isp_chk(rx[15:8], 8'h53);
        `isp_chk(rx[31:16], 16'h0000);
    endtask : t_enable

    task automatic t_erase;
        timed(32'hAC80_0000, 32'hF000_0000, n);
        `isp_chk(n, ER_CYC);
        `isp_chk(rx[0], 1'b1);
        send(32'hF000_0000);
        `isp_chk(rx[0], 1'b0);
        send(32'hA000_0500);
        `isp_chk(rx[7:0], 8'hFF);
        send(32'h2000_1300);
        `isp_chk(rx[7:0], 8'hFF);
    endtask : t_erase

    task automatic t_eeprom;
        timed(32'hC000_0A3C, 32'h0000_0000, n);
        `isp_chk(n, WR_CYC);
        send(32'hA000_0A00);
        `isp_chk(rx[7:0], 8'h3C);
        send(32'hC100_0177);
        timed(32'hC200_0800, 32'h0000_0000, n);
        `isp_chk(n, WR_CYC);
        send(32'hA000_0900);
        `isp_chk(rx[7:0], 8'h77);
        send(32'hA000_0A00);
        `isp_chk(rx[7:0], 8'h3C);
    endtask : t_eeprom

    task automatic t_flash;
        send(32'h4000_0311);
        send(32'h4800_0322);
        timed(32'h4C00_1000, 32'h0000_0000, n);
        `isp_chk(n, WR_CYC);
        send(32'h2000_1300);
        `isp_chk(rx[7:0], 8'h11);
        send(32'h2800_1300);
        `isp_chk(rx[7:0], 8'h22);
    endtask : t_flash

    task automatic t_fuse;
        timed(32'hACA8_00E2, 32'h0000_0000, n);
        `isp_chk(n, WR_CYC);
        send(32'h5808_0000);
        `isp_chk(rx[7:0], 8'hE2);
        timed(32'hACE0_0000, 32'h0000_0000, n);
        `isp_chk(n, WR_CYC);
        send(32'h5800_0000);
        `isp_chk(rx[7:0], 8'hC0);
    endtask : t_fuse

    task automatic t_exit;
        i_isp_prog_model.set_pin(1'b1);
        `isp_chk(prog_mode, 1'b0);
        `isp_chk(miso_oe, 1'b0);
        i_isp_prog_model.set_pin(1'b0);
        send(32'hC000_0500);
        `isp_chk(busy, 1'b0);
        send(32'hA000_0500);
        `isp_chk(rx[7:0], 8'hFF);
    endtask : t_exit

    initial
    begin
        sys_rst = 1'b1;
        ce = 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (20) @(posedge clk);
        t_enable();
        t_erase();
        t_eeprom();
        t_flash();
        t_fuse();
        t_exit();
        report_and_stop();
    end
endmodule : serial_isp_programming_port_tb
